// File: core/microstep_wave_table.v
// Purpose: programmable microstep wave table with AXI4-Lite registers
// Assumes: one step pulse moves the position counter by one microstep
// Notes: coil values lag a step by three clocks; start values apply at zero pass, table edits from the next step
`timescale 1ns/1ps
`include "wave_table_defs.vh"

module microstep_wave_table #(
	parameter CNT_W = 10                      // position counter width
) (
	input  wire              aclk,
	input  wire              aresetn,
	// microstep sequencer request
	input  wire              step_pulse,      // one-cycle advance request
	input  wire              step_dir,        // 1 counts up, 0 counts down
	// AXI4-Lite slave
	input  wire [7:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [7:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	// coil currents to the chopper
	output reg  [8:0]        coil_a_current_value,
	output reg  [8:0]        coil_b_current_value,
	output reg  [CNT_W-1:0]  microstep_position_counter
);

	// programmable state
	reg  [255:0]     table_ff;          // increment bits, entry n at bit n
	reg  [23:0]      segment_cfg_ff;    // segment_boundary_first/second/third
	reg  [7:0]       slope_cfg_ff;      // segment0_base_slope .. segment3
	reg  [7:0]       start_first_ff;    // first coil value at position zero
	reg  [7:0]       second_coil_start_value; // second coil value at position zero
	// sequencer state
	reg  [CNT_W-1:0] cnt_d_ff;          // counter as seen by the walkers
	reg              load_ff;           // absolute reload pending
	// bus state
	reg              aw_have_ff;        // write address captured
	reg              w_have_ff;         // write data captured
	reg  [7:0]       waddr_ff;
	reg  [31:0]      wdata_ff;
	reg  [3:0]       wstrb_ff;
	reg  [31:0]      nxt_rdata;
	reg              nxt_rerr;
	wire signed [9:0] mag_a;
	wire signed [9:0] mag_b;
	wire [CNT_W-1:0] pos_b;
	integer          k;

	wire [23:0] segment_boundary_all = segment_cfg_ff;

	// quarter index: forward in even quadrants, mirrored in odd ones
	function [7:0] quarter_index;
		input [CNT_W-1:0] c;
		begin
			quarter_index = c[CNT_W-2] ? ~c[7:0] : c[7:0]; // [RL1] [RL14]
		end
	endfunction

	// signed coil value: negative in the second half period
	function [8:0] signed_value;
		input             neg;
		input signed [9:0] m;
		reg   signed [9:0] t;
		begin
			t = neg ? -m : m;                   // [RL14]
			signed_value = t[8:0];
		end
	endfunction

	// merge a bus word into a register under the byte strobes
	function [31:0] strobe_merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0]  stb;
		integer      b;
		begin
			strobe_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (stb[b])
					strobe_merge[b*8 +: 8] = dat[b*8 +: 8];
		end
	endfunction

	// second coil sits a quarter period ahead of the first
	assign pos_b = cnt_d_ff + {2'b01, {(CNT_W-2){1'b0}}}; // [RL15]

	// segment word merged under the byte strobes; only its low 24 bits are kept
	wire [31:0] seg_merged = strobe_merge({8'h00, segment_cfg_ff}, wdata_ff, wstrb_ff);

	// position counter and zero pass detection
	always @(posedge aclk) begin
		if (!aresetn) begin
			microstep_position_counter <= {CNT_W{1'b0}};
			cnt_d_ff                   <= {CNT_W{1'b0}};
			load_ff                    <= 1'b1;  // start from absolute values
		end else begin
			cnt_d_ff <= microstep_position_counter;
			load_ff  <= 1'b0;
			if (step_pulse) begin
				// counter wraps through the whole 360 degree wave
				if (step_dir)
					microstep_position_counter <= microstep_position_counter + 1'b1; // [RL2]
				else
					microstep_position_counter <= microstep_position_counter - 1'b1; // [RL2]
				// reaching zero reloads, so drift or table edits never linger
				if ((step_dir && microstep_position_counter == {CNT_W{1'b1}}) ||
				    (!step_dir && microstep_position_counter == {{(CNT_W-1){1'b0}}, 1'b1}))
					load_ff <= 1'b1;                // [RL9]
			end
		end
	end

	// first coil walker, starts at entry 0
	quarter_wave_walker u_walk_a (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.load       (load_ff),
		.load_idx   (8'h00),
		.load_val   (start_first_ff),         // [RL10]
		.tgt_idx    (quarter_index(cnt_d_ff)),
		.table_bits (table_ff),
		.boundaries (segment_boundary_all),
		.slopes     (slope_cfg_ff),
		.mag        (mag_a)
	);

	// second coil walker, starts at the mirrored last entry
	quarter_wave_walker u_walk_b (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.load       (load_ff),
		.load_idx   (8'hFF),
		.load_val   (second_coil_start_value), // [RL11]
		.tgt_idx    (quarter_index(pos_b)),
		.table_bits (table_ff),
		.boundaries (segment_boundary_all),
		.slopes     (slope_cfg_ff),
		.mag        (mag_b)
	);

	// coil outputs refresh every clock, so every microstep lands here
	always @(posedge aclk) begin
		if (!aresetn) begin
			coil_a_current_value <= 9'h000;
			coil_b_current_value <= 9'h000;
		end else begin
			coil_a_current_value <= signed_value(cnt_d_ff[CNT_W-1], mag_a); // [RL8] [RL14]
			coil_b_current_value <= signed_value(pos_b[CNT_W-1], mag_b);    // [RL8] [RL15]
		end
	end

	// write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			waddr_ff      <= 8'h00;
			wdata_ff      <= 32'h00000000;
			wstrb_ff      <= 4'h0;
			// power-up contents give a sine wave
			table_ff <= {`RST_TABLE7, `RST_TABLE6, `RST_TABLE5, `RST_TABLE4,
			             `RST_TABLE3, `RST_TABLE2, `RST_TABLE1, `RST_TABLE0}; // [RL12]
			segment_cfg_ff          <= `RST_SEGMENT_CFG; // [RL12]
			slope_cfg_ff            <= `RST_SLOPE_CFG;   // [RL12]
			start_first_ff          <= `RST_START_FIRST;
			second_coil_start_value <= `RST_START_SECOND;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_ff      <= s_axi_awaddr;
				aw_have_ff    <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
				w_have_ff    <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// both halves present: commit and answer
			if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				if (waddr_ff[7:5] == 3'b000) begin
					// one table word; range check unneeded, 8 words fill 0x00..0x1C
					for (k = 0; k < 8; k = k + 1)
						if (waddr_ff[4:2] == k[2:0])
							table_ff[k*32 +: 32] <= strobe_merge(table_ff[k*32 +: 32],
							                       wdata_ff, wstrb_ff); // [RL3]
				end else if (waddr_ff[7:2] == `OFS_SEGMENT_CFG >> 2)
					segment_cfg_ff <= seg_merged[23:0]; // [RL7]
				else if (waddr_ff[7:2] == `OFS_SLOPE_CFG >> 2)
					slope_cfg_ff <= wstrb_ff[0] ? wdata_ff[7:0] : slope_cfg_ff; // [RL6]
				else if (waddr_ff[7:2] == `OFS_START_CFG >> 2) begin
					if (wstrb_ff[0])
						start_first_ff <= wdata_ff[`START_FIRST_LSB +: 8]; // [RL10]
					if (wstrb_ff[2])
						second_coil_start_value <= wdata_ff[`START_SECOND_LSB +: 8]; // [RL11]
				end else if (waddr_ff[7:2] != `OFS_POSITION >> 2 &&
				             waddr_ff[7:2] != `OFS_CURRENTS >> 2)
					s_axi_bresp <= `RESP_DECERR;  // unmapped
				// writes to the read-only words are ignored with OKAY
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read decode
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_rerr  = 1'b0;
		if (s_axi_araddr[7:5] == 3'b000)
			nxt_rdata = table_ff[s_axi_araddr[4:2]*32 +: 32];
		else begin
			case (s_axi_araddr[7:2])
				`OFS_SEGMENT_CFG >> 2: nxt_rdata = {8'h00, segment_cfg_ff};
				`OFS_SLOPE_CFG >> 2:   nxt_rdata = {24'h000000, slope_cfg_ff};
				`OFS_START_CFG >> 2:   nxt_rdata = {8'h00, second_coil_start_value,
				                                    8'h00, start_first_ff};
				`OFS_POSITION >> 2:    nxt_rdata = {{(32-CNT_W){1'b0}},
				                                    microstep_position_counter};
				// currents sign-extended into each half word
				`OFS_CURRENTS >> 2:    nxt_rdata = {{7{coil_b_current_value[8]}},
				                                    coil_b_current_value,
				                                    {7{coil_a_current_value[8]}},
				                                    coil_a_current_value};
				default:               nxt_rerr  = 1'b1;
			endcase
		end
	end

	// read channel: answer one clock after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= nxt_rdata;
			s_axi_rresp   <= nxt_rerr ? `RESP_DECERR : `RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // microstep_wave_table

// File: core/wave_table_defs.vh
// Purpose: constants for the microstep wave table block (offsets, fields, resets)
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: reset contents of the table and segment words describe a sine quarter
// Overview of operation
// RL1: store quarter wave, mirror to full period
// RL2: 10-bit position counter indexes whole wave
// RL3: 256 increment bits in eight registers
// RL4: step adds base slope, plus one if bit
// RL5: zero slope with set bit adds one
// RL6: base slope selectable as -1, 0, 1, 2
// RL7: three boundaries split quarter into four segments
// RL8: each microstep refreshes both coil current values
// RL9: counter passing zero reloads absolute coil values
// RL10: programmable start value for first coil
// RL11: programmable start value for second coil
// RL12: table preloaded with sine at reset
// RL13: software keeps wave within -248 to 248
// RL14: upper counter bits pick quadrant, mirror, sign
// RL15: second coil uses counter plus quarter period
`ifndef WAVE_TABLE_DEFS_VH
`define WAVE_TABLE_DEFS_VH

// register byte offsets
`define OFS_TABLE_BASE   8'h00
`define OFS_SEGMENT_CFG  8'h20
`define OFS_SLOPE_CFG    8'h24
`define OFS_START_CFG    8'h28
`define OFS_POSITION     8'h30
`define OFS_CURRENTS     8'h34

// field positions
`define START_FIRST_LSB  0
`define START_SECOND_LSB 16
`define COIL_A_CURRENT_VALUE_LSB        0
`define COIL_B_CURRENT_VALUE_LSB        16

// reset contents: sine quarter
`define RST_TABLE0       32'hAAAAB554
`define RST_TABLE1       32'h4A9554AA
`define RST_TABLE2       32'h24492929
`define RST_TABLE3       32'h10104222
`define RST_TABLE4       32'hFBFFFFFF
`define RST_TABLE5       32'hB5BB777D
`define RST_TABLE6       32'h49295556
`define RST_TABLE7       32'h00404222
`define RST_SEGMENT_CFG  24'hFFFF80
`define RST_SLOPE_CFG    8'h56
`define RST_START_FIRST  8'h00
`define RST_START_SECOND 8'hF7

// bus answers
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

`endif

// File: core/quarter_wave_walker.v
// Purpose: follows one coil's position in the quarter table, keeping its magnitude
// Assumes: the target index moves by at most one entry per clock
// Notes: magnitude is rebuilt purely incrementally between absolute loads
`timescale 1ns/1ps
`include "wave_table_defs.vh"

module quarter_wave_walker (
	input  wire               aclk,
	input  wire               aresetn,
	input  wire               load,        // absolute initialisation strobe
	input  wire [7:0]         load_idx,    // index that the load value belongs to
	input  wire [7:0]         load_val,    // absolute magnitude at that index
	input  wire [7:0]         tgt_idx,     // quarter index the coil should sit at
	input  wire [255:0]       table_bits,  // increment bit per entry
	input  wire [23:0]        boundaries,  // three segment boundaries
	input  wire [7:0]         slopes,      // four two-bit slope codes
	output wire signed [9:0]  mag          // current magnitude
);

	reg        [7:0]  idx_ff;   // entry the magnitude belongs to
	reg signed [9:0]  mag_ff;   // running magnitude

	assign mag = mag_ff;

	// increment from entry i to i+1: segment slope plus the entry's bit
	function signed [9:0] step_delta;
		input [7:0]   i;
		input [255:0] bits;
		input [23:0]  bnd;
		input [7:0]   slp;
		reg   [1:0]   code;
		begin
			code = slp[7:6];
			if (i < bnd[7:0])                    // [RL7]
				code = slp[1:0];
			else if (i < bnd[15:8])
				code = slp[3:2];
			else if (i < bnd[23:16])
				code = slp[5:4];
			// code 0..3 means base -1..+2, the bit adds one more
			step_delta = {8'h00, code} - 10'sh001 + {9'h000, bits[i]}; // [RL4] [RL5] [RL6]
		end
	endfunction

	// follow the target one entry at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			idx_ff <= 8'h00;
			mag_ff <= 10'sh000;
		end else if (load) begin
			idx_ff <= load_idx;                  // [RL9]
			mag_ff <= {2'b00, load_val};
		end else if (tgt_idx == idx_ff + 8'h01) begin
			idx_ff <= tgt_idx;
			mag_ff <= mag_ff + step_delta(idx_ff, table_bits, boundaries, slopes); // [RL4]
		end else if (tgt_idx == idx_ff - 8'h01) begin
			// walking back undoes the increment that led into this entry
			idx_ff <= tgt_idx;
			mag_ff <= mag_ff - step_delta(tgt_idx, table_bits, boundaries, slopes); // [RL4]
		end
	end

endmodule // quarter_wave_walker

// File: testbench/wave_table_checker.sv
// Purpose: port timing checks for the microstep wave table
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound to the design top; coil values are only checked for stillness here
`timescale 1ns/1ps
module wave_table_checker #(
	parameter CNT_W = 10                    // position counter width
) (
	input wire             aclk,
	input wire             aresetn,
	input wire             step_pulse,
	input wire             step_dir,
	input wire             s_axi_awvalid,
	input wire             s_axi_awready,
	input wire             s_axi_wvalid,
	input wire             s_axi_wready,
	input wire             s_axi_bvalid,
	input wire             s_axi_bready,
	input wire [7:0]       s_axi_araddr,
	input wire             s_axi_arvalid,
	input wire             s_axi_arready,
	input wire [31:0]      s_axi_rdata,
	input wire [1:0]       s_axi_rresp,
	input wire             s_axi_rvalid,
	input wire [8:0]       coil_a_current_value,
	input wire [8:0]       coil_b_current_value,
	input wire [CNT_W-1:0] microstep_position_counter
);
	// all checks share the clock and sleep while reset is low
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	cnt_up_a: assert property (step_pulse && step_dir |=>
		microstep_position_counter == $past(microstep_position_counter) + 1'b1)
		else $error("counter missed an up step");
	cnt_down_a: assert property (step_pulse && !step_dir |=>
		microstep_position_counter == $past(microstep_position_counter) - 1'b1)
		else $error("counter missed a down step");
	cnt_hold_a: assert property (!step_pulse |=> $stable(microstep_position_counter))
		else $error("counter moved without a step");
	// coil values settle three edges after a step, so four quiet cycles must freeze them
	coil_still_a: assert property (!step_pulse [*4] |=>
		$stable(coil_a_current_value) && $stable(coil_b_current_value))
		else $error("coil value changed without a step");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready) else $error("write response did not clear");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read data late");
	rd_decerr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h37
		|=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule // wave_table_checker

bind microstep_wave_table wave_table_checker #(.CNT_W(CNT_W)) wave_table_checker_inst (.*);

// File: testbench/microstep_wave_table_bench.sv
// Purpose: self-checking bench for the microstep wave table
// Assumes: 20 MHz clock, reset held 12 cycles
// Notes: expected wave is rebuilt here from shadow copies of the registers
`timescale 1ns/1ps
`include "wave_table_defs.vh"
module microstep_wave_table_bench;
	reg         aclk = 1'b0, aresetn = 1'b0, step_pulse = 1'b0, step_dir = 1'b1;
	reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg  [31:0] s_axi_wdata = 32'h0;
	reg  [3:0]  s_axi_wstrb = 4'hF;                 // full words except in the low-lane start write
	reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg         s_axi_arvalid = 0, s_axi_rready = 0;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [8:0]  coil_a_current_value, coil_b_current_value;
	wire [9:0]  microstep_position_counter;
	integer     err_count = 0, check_count = 0, cyc = 0, i, k;
	reg  [31:0] sh_tbl [0:7];                       // shadow of the register contents
	reg  [23:0] sh_bnd;
	reg  [7:0]  sh_slp, sh_s1, sh_s2;
	reg  [9:0]  ma [0:255], mb [0:255];             // expected magnitudes per coil
	reg  [9:0]  pos;                                // expected counter
	reg  [31:0] rd;
	reg  [1:0]  rs;
	reg  [41:0] rows [0:13];                        // address, read data, response

	microstep_wave_table microstep_wave_table_inst (.*);

	always #25 aclk = ~aclk;

	// hang guard: a stuck handshake ends the run as a failure
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count = err_count + 1;
			report_and_stop;
		end
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one write; each channel dropped at the edge that takes it
	task wr(input [7:0] a, input [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd_word(input [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// table step from entry i to i+1: segment slope plus the entry bit
	function [9:0] inc(input [7:0] i);
		reg [2:0] g;
		g = (i < sh_bnd[7:0]) ? 3'd0 : (i < sh_bnd[15:8]) ? 3'd2 : (i < sh_bnd[23:16]) ? 3'd4 : 3'd6;
		inc = {8'h0, sh_slp[g +: 2]} - 10'd1 + sh_tbl[i[7:5]][i[4:0]];
	endfunction

	// coil A walks up from entry 0, coil B down from entry 255
	task build;
		ma[0] = {2'b0, sh_s1};
		for (i = 0; i < 255; i = i + 1) ma[i+1] = ma[i] + inc(i[7:0]);
		mb[255] = {2'b0, sh_s2};
		for (i = 254; i >= 0; i = i - 1) mb[i] = mb[i+1] - inc(i[7:0]);
	endtask

	function [31:0] expv(input [9:0] c, input b);
		reg [9:0] p, v;
		p = c + (b ? 10'd256 : 10'd0);
		v = b ? mb[p[8] ? ~p[7:0] : p[7:0]] : ma[p[8] ? ~p[7:0] : p[7:0]];
		v = p[9] ? -v : v;
		expv = {23'h0, v[8:0]};
	endfunction

	// n back-to-back steps in one direction, then compare once settled
	task step(input d, input integer n, input ck);
		@(posedge aclk);
		step_dir <= d;
		step_pulse <= 1'b1;
		repeat (n) @(posedge aclk);
		step_pulse <= 1'b0;
		pos = d ? pos + n[9:0] : pos - n[9:0];
		repeat (5) @(posedge aclk);
		chk("counter", {22'h0, microstep_position_counter}, {22'h0, pos});
		if (ck) chk("coil_a", {23'h0, coil_a_current_value}, expv(pos, 1'b0));
		if (ck) chk("coil_b", {23'h0, coil_b_current_value}, expv(pos, 1'b1));
	endtask

	initial begin
		{sh_tbl[0], sh_tbl[1], sh_tbl[2], sh_tbl[3]} = {`RST_TABLE0, `RST_TABLE1, `RST_TABLE2, `RST_TABLE3};
		{sh_tbl[4], sh_tbl[5], sh_tbl[6], sh_tbl[7]} = {`RST_TABLE4, `RST_TABLE5, `RST_TABLE6, `RST_TABLE7};
		sh_bnd = `RST_SEGMENT_CFG;
		sh_slp = `RST_SLOPE_CFG;
		sh_s1 = `RST_START_FIRST;
		sh_s2 = `RST_START_SECOND;
		for (k = 0; k < 8; k = k + 1) rows[k] = {k[5:0], 2'b00, sh_tbl[k], `RESP_OKAY};
		rows[8] = {8'h20, 8'h00, sh_bnd, `RESP_OKAY};
		rows[9] = {8'h24, 24'h0, sh_slp, `RESP_OKAY};
		rows[10] = {8'h28, 8'h00, sh_s2, 8'h00, sh_s1, `RESP_OKAY};
		rows[11] = {8'h30, 32'h0, `RESP_OKAY};
		rows[12] = {8'h34, 32'h00F70000, `RESP_OKAY};
		rows[13] = {8'h38, 32'h0, `RESP_DECERR};
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		// reset contents and the unmapped word, one row each
		for (k = 0; k < 14; k = k + 1) begin
			rd_word(rows[k][41:34]);
			chk("rdata", rd, rows[k][33:2]);
			chk("rresp", {30'h0, rs}, {30'h0, rows[k][1:0]});
		end
		// writes to the read-only counter and to a hole
		wr(8'h30, 32'h155);
		chk("bresp", {30'h0, rs}, {30'h0, `RESP_OKAY});
		wr(8'h3C, 32'h1);
		chk("bresp", {30'h0, rs}, {30'h0, `RESP_DECERR});
		pos = 10'h0;
		build;
		for (k = 0; k < 1024; k = k + 1) step(1'b1, 1, 1'b1);
		// custom wave with all four slope codes and moved starts
		for (k = 0; k < 8; k = k + 1) begin
			sh_tbl[k] = 32'h0F0F0F0F;
			wr({k[5:0], 2'b00}, sh_tbl[k]);
		end
		// swing stays between -30 and 240, inside the chopper headroom
		sh_bnd = 24'hF08040;
		wr(8'h20, {8'h00, sh_bnd});
		sh_slp = 8'hE4;
		wr(8'h24, {24'h0, sh_slp});
		sh_s1 = 8'h02;
		sh_s2 = 8'hF0;
		wr(8'h28, 32'h00F00002);
		rd_word(8'h28);
		chk("start", rd, 32'h00F00002);
		// start edits only count after the counter comes back to zero; table edits enter the next step at once
		step(1'b1, 1, 1'b0);
		build;
		step(1'b0, 1, 1'b1);
		for (k = 0; k < 1024; k = k + 1) step(1'b0, 1, 1'b1);
		step(1'b1, 7, 1'b1);
		step(1'b0, 7, 1'b1);
		// second reset in mid-run restores the defaults
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd_word(8'h28);
		chk("start", rd, 32'h00F70000);
		chk("counter", {22'h0, microstep_position_counter}, 32'h0);
		chk("coil_a", {23'h0, coil_a_current_value}, {24'h0, `RST_START_FIRST});
		chk("coil_b", {23'h0, coil_b_current_value}, {24'h0, `RST_START_SECOND});
		// a low-lane write moves only the first start value
		s_axi_wstrb <= 4'h1;
		wr(8'h28, 32'h00330011);
		s_axi_wstrb <= 4'hF;
		rd_word(8'h28);
		chk("start_lane", rd, 32'h00F70011);
		report_and_stop;
	end
endmodule // microstep_wave_table_bench
